// *** core/igs_map.svh ***
// register map, field positions and reset values of the interrupt gating block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef IGS_MAP_SVH
`define IGS_MAP_SVH
// byte addresses of the registers
`define IGS_ADDR_IRQ_ENABLE_MASK 12'h000
`define IGS_ADDR_IRQ_PENDING_STATUS 12'h004
`define IGS_ADDR_PORT_A_CONTROL 12'h008
`define IGS_ADDR_PORT_B_CONTROL 12'h00c
`define IGS_ADDR_NMI_ENABLE 12'h010
`define IGS_ADDR_RAW_STATUS 12'h014
// pending/enable bit positions (maskable sources of the sound/serial unit)
`define IGS_BIT_TIMER1 0
`define IGS_BIT_TIMER2 1
`define IGS_BIT_TIMER4 2
`define IGS_BIT_SER_OUT_COMPLETE 3
`define IGS_BIT_SER_OUT_NEEDED 4
`define IGS_BIT_SER_IN_READY 5
`define IGS_BIT_KEY_PRESSED 6
`define IGS_BIT_BREAK_KEY 7
// positions of the pins inside the synchronised level vector; the event
// bundle is packed with the sound/serial byte on top and system reset at 0
`define IGS_LVL_WIDTH 14
`define IGS_LVL_SOUND_HI 13
`define IGS_LVL_SOUND_LO 6
`define IGS_LVL_SHIFT_IDLE 5
`define IGS_LVL_PROCEED 4
`define IGS_LVL_INTERRUPT 3
`define IGS_LVL_DLIST 2
`define IGS_LVL_VBLANK 1
`define IGS_LVL_SYSRST 0
// parallel port control fields
`define IGS_PCTL_ENABLE 0
`define IGS_PCTL_STATUS 7
// nonmaskable enable fields; system reset has no enable, 2 is its raw status bit
`define IGS_NMI_DLIST 0
`define IGS_NMI_VBLANK 1
`define IGS_NMI_SYSRST 2
// reset values
`define IGS_RST_BYTE 8'h00
`define IGS_RST_NMI_EN 2'h0
`define IGS_RST_ZERO 32'h0000_0000
`endif

// *** core/igs_pkg.sv ***
// types shared by the interrupt gating block
// assumes igs_map.svh supplies the numbers
package igs_pkg;
  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } igs_apb_req_t;
  // raw event inputs of all sources
  typedef struct packed {
    logic [7:0] sound_evt;   // one bit per maskable sound/serial source
    logic ser_shift_busy_n;  // high while transmit shift register is empty
    logic proceed_evt;       // serial bus proceed line event
    logic interrupt_evt;     // serial bus interrupt line event
    logic dlist_evt;         // display list nonmaskable event
    logic vblank_evt;        // vertical blank nonmaskable event
    logic sys_reset_evt;     // system reset key event
  } igs_events_t;
endpackage : igs_pkg

// *** core/igs_sync.sv ***
// two-flop synchroniser for pin level inputs
// assumes one clock, synchronous reset
module igs_sync (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  logic meta_r; // first stage, read only by the second
  // plain two-stage chain
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // igs_sync

// *** core/igs_port_ctl.sv ***
// one parallel port control register with its interrupt input
// assumes a synchronised one-cycle event and decoded write/read strobes
`include "igs_map.svh"
module igs_port_ctl (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic evt,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  output logic [7:0] ctl,
  output logic irq
);
  typedef struct packed {
    logic [6:0] bits; // enable and user bits 6:0
    logic flag;       // interrupt status, bit 7
  } igs_pctl_st_t;
  igs_pctl_st_t st_r;
  igs_pctl_st_t st_nxt;
  // write keeps the flag; read clears it; a new event wins over the read
  always_comb begin
    st_nxt = st_r;
    if (wr) begin
      st_nxt.bits = wdata[6:0];
    end
    if (rd) begin
      st_nxt.flag = 1'b0;
    end
    if (evt) begin
      st_nxt.flag = 1'b1;
    end
  end
  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign ctl = {st_r.flag, st_r.bits};
  assign irq = st_r.flag & st_r.bits[`IGS_PCTL_ENABLE];
endmodule // igs_port_ctl

// *** core/igs_gate.sv ***
// interrupt gating and status for a home computer: apb registers,
// maskable request to the processor and nonmaskable request.
// assumes one 50 MHz clock, synchronous reset, event pins asynchronous.
`include "igs_map.svh"
module igs_gate (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] sound_evt,
  input wire logic ser_shift_busy_n,
  input wire logic proceed_evt,
  input wire logic interrupt_evt,
  input wire logic dlist_evt,
  input wire logic vblank_evt,
  input wire logic sys_reset_evt,
  output logic irq_n,
  output logic nmi_n
);
  // pin map of the synchronised level vector, top bit first:
  //   13..6  sound/serial event byte, one bit per maskable source
  //   5      transmit shifter idle level, feeds status bit 3 live
  //   4      serial bus proceed line, sets the port a flag
  //   3      serial bus interrupt line, sets the port b flag
  //   2      display list event
  //   1      vertical blank event
  //   0      system reset key
  // the order follows the packed event bundle, so the bundle and this
  // vector must change together; the map header names every position
  //
  // timing of an event pin, counted in rising edges of ref_clk:
  //   edge 1  first synchroniser flop takes the pin
  //   edge 2  second flop, the level becomes visible to logic
  //   edge 3  the rising edge is seen and the status bit latches
  //   edge 4  the registered request line falls
  // a pin must therefore stay high across at least one edge, or the
  // synchroniser may never see it; a shorter glitch is lost on purpose
  //
  // bus side:
  //   the slave never waits, pready is tied high
  //   read data is chosen in the setup phase and registered, so it
  //   stands through the whole access phase
  //   writes land at the edge that closes the access phase
  //   reads of a port control register clear its flag at that same edge
  //
  // maskable status:
  //   a zero written to an enable bit drops its pending bit
  //   an event in the same cycle as that write still latches (set wins)
  //   bit 3 is never latched; it mirrors the transmit shifter level
  //
  // nonmaskable status:
  //   display list and vertical blank are gated by their enable bits
  //   system reset has no enable and always reaches the processor
  //   software clears pending bits by writing ones to the raw status
  //
  // limitation: the request outputs are registered, so a cleared status
  // is seen on the request pin one edge later than in the status register
  //
  // all block state in one struct
  typedef struct packed {
    logic [7:0] en;         // irq_enable_mask, write-only
    logic [7:0] pend;       // latched maskable status
    logic [1:0] nmi_en;     // display list and vertical blank enables
    logic [2:0] nmi_pend;   // reset, vblank, dlist latched
    logic [13:0] evt_d;     // previous synchronised levels for edge detect
    logic [31:0] rdata;     // read data register
    logic irq;              // registered maskable request
    logic nmi;              // registered nonmaskable request
  } igs_state_t;
  igs_state_t s_r;
  igs_state_t s_nxt;
  igs_pkg::igs_apb_req_t req;  // bundled bus request
  igs_pkg::igs_events_t ev_raw; // raw pins
  logic [13:0] lvl;             // synchronised pin levels
  logic [13:0] rise;            // rising edges of the levels
  logic [7:0] pa_ctl;           // port a control read value
  logic [7:0] pb_ctl;           // port b control read value
  logic pa_irq;                 // port a gated request
  logic pb_irq;                 // port b gated request
  logic wr_acc;                 // write access phase
  logic rd_acc;                 // read access phase
  logic [7:0] live_pend;        // pending with live bit 3
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                 pwdata: pwdata};
  // pins gathered in one bundle; field order fixes the level vector
  assign ev_raw = '{
    sound_evt: sound_evt,
    ser_shift_busy_n: ser_shift_busy_n,
    proceed_evt: proceed_evt,
    interrupt_evt: interrupt_evt,
    dlist_evt: dlist_evt,
    vblank_evt: vblank_evt,
    sys_reset_evt: sys_reset_evt
  };
  // every pin passes two flops before any logic looks at it
  genvar gi;
  generate
    for (gi = 0; gi < `IGS_LVL_WIDTH; gi++) begin : g_sync
      igs_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(ev_raw[gi]),
        .q(lvl[gi])
      );
    end
  endgenerate
  // events are taken on rising edges so a held line does not retrigger
  assign rise = lvl & ~s_r.evt_d;
  // zero-wait slave: access phase completes at once
  assign wr_acc = req.psel & req.penable & req.pwrite;
  assign rd_acc = req.psel & req.penable & ~req.pwrite;
  // port a fed by proceed line
  igs_port_ctl u_port_a (
    .ref_clk(ref_clk),
    .srst(srst),
    .evt(rise[`IGS_LVL_PROCEED]),
    .wr(wr_acc & (req.paddr == `IGS_ADDR_PORT_A_CONTROL)),
    .rd(rd_acc & (req.paddr == `IGS_ADDR_PORT_A_CONTROL)),
    .wdata(req.pwdata[7:0]),
    .ctl(pa_ctl),
    .irq(pa_irq)
  );
  // port b fed by interrupt line
  igs_port_ctl u_port_b (
    .ref_clk(ref_clk),
    .srst(srst),
    .evt(rise[`IGS_LVL_INTERRUPT]),
    .wr(wr_acc & (req.paddr == `IGS_ADDR_PORT_B_CONTROL)),
    .rd(rd_acc & (req.paddr == `IGS_ADDR_PORT_B_CONTROL)),
    .wdata(req.pwdata[7:0]),
    .ctl(pb_ctl),
    .irq(pb_irq)
  );
  // bit 3 follows the shift register
  always_comb begin
    live_pend = s_r.pend;
    live_pend[`IGS_BIT_SER_OUT_COMPLETE] = lvl[`IGS_LVL_SHIFT_IDLE];
  end
  // next-state logic: events, register writes, read data, requests
  always_comb begin
    s_nxt = s_r;
    s_nxt.evt_d = lvl;
    if (wr_acc && req.paddr == `IGS_ADDR_IRQ_ENABLE_MASK) begin
      s_nxt.en = req.pwdata[7:0];
      s_nxt.pend = s_r.pend & req.pwdata[7:0];
    end
    s_nxt.pend = s_nxt.pend | rise[`IGS_LVL_SOUND_HI:`IGS_LVL_SOUND_LO];
    s_nxt.pend[`IGS_BIT_SER_OUT_COMPLETE] = 1'b0;
    if (wr_acc && req.paddr == `IGS_ADDR_NMI_ENABLE) begin
      s_nxt.nmi_en = req.pwdata[1:0];
      s_nxt.nmi_pend = s_r.nmi_pend & {1'b1, req.pwdata[`IGS_NMI_VBLANK],
                                       req.pwdata[`IGS_NMI_DLIST]};
    end
    // nmi status clears by writing ones to the raw status register
    if (wr_acc && req.paddr == `IGS_ADDR_RAW_STATUS) begin
      s_nxt.nmi_pend = s_nxt.nmi_pend & ~req.pwdata[2:0];
    end
    // pending order is reset, vblank, dlist from the top
    s_nxt.nmi_pend = s_nxt.nmi_pend | {rise[`IGS_LVL_SYSRST],
                                       rise[`IGS_LVL_VBLANK],
                                       rise[`IGS_LVL_DLIST]};
    // read data mux; unmapped and write-only read zero
    s_nxt.rdata = `IGS_RST_ZERO;
    if (req.psel && !req.penable && !req.pwrite) begin
      unique case (req.paddr)
        `IGS_ADDR_IRQ_ENABLE_MASK: begin
          s_nxt.rdata = `IGS_RST_ZERO;
        end
        // pending status with the live shifter bit merged in
        `IGS_ADDR_IRQ_PENDING_STATUS: begin
          s_nxt.rdata = {24'h00_0000, live_pend};
        end
        // port a flag is read here and cleared in the access phase
        `IGS_ADDR_PORT_A_CONTROL: begin
          s_nxt.rdata = {24'h00_0000, pa_ctl};
        end
        // port b flag is read here and cleared in the access phase
        `IGS_ADDR_PORT_B_CONTROL: begin
          s_nxt.rdata = {24'h00_0000, pb_ctl};
        end
        // nonmaskable enables read back as written
        `IGS_ADDR_NMI_ENABLE: begin
          s_nxt.rdata = {30'h0000_0000, s_r.nmi_en};
        end
        // nonmaskable pending bits, reset on top
        `IGS_ADDR_RAW_STATUS: begin
          s_nxt.rdata = {29'h0000_0000, s_r.nmi_pend};
        end
        // unmapped offsets read zero, no error
        default: begin
          s_nxt.rdata = `IGS_RST_ZERO;
        end
      endcase
    end else if (req.psel && req.penable) begin
      s_nxt.rdata = s_r.rdata;
    end
    s_nxt.irq = (|(live_pend & s_r.en)) | pa_irq | pb_irq;
    s_nxt.nmi = s_r.nmi_pend[2] |
                (s_r.nmi_pend[1] & s_r.nmi_en[`IGS_NMI_VBLANK]) |
                (s_r.nmi_pend[0] & s_r.nmi_en[`IGS_NMI_DLIST]);
  end
  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq_n = ~s_r.irq;
  assign nmi_n = ~s_r.nmi;
endmodule // igs_gate

// *** verification/igs_gate_sva.sv ***
// checker on the ports of the interrupt gating block
// assumes it is bound to igs_gate; one clock, sync reset
module igs_gate_sva (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0] sound_evt,
  input wire logic ser_shift_busy_n,
  input wire logic proceed_evt,
  input wire logic vblank_evt,
  input wire logic sys_reset_evt,
  input wire logic irq_n,
  input wire logic nmi_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [10:0] sh_r; // shadow: 7:0 mask, 8 port a, 9 port b, 10 vblank
  wire logic acc = psel && penable;
  // follow software writes, since the enables are not visible at the ports
  always_ff @(posedge ref_clk) begin
    if (srst) sh_r <= 11'h000;
    else if (acc && pwrite) case (paddr)
      12'h000: sh_r[7:0] <= pwdata[7:0];
      12'h008: sh_r[8] <= pwdata[0];
      12'h00c: sh_r[9] <= pwdata[0];
      12'h010: sh_r[10] <= pwdata[1];
      default: ;
    endcase
  end
  sequence s_rd(logic [11:0] a); acc && !pwrite && paddr == a; endsequence
  property p_gate; (sh_r[9:0] == 10'h000)[*3] |-> irq_n; endproperty
  a_gate: assert property (p_gate) else $error("irq with all disabled");
  property p_raise; |(sh_r[7:0] & 8'hf7 & sound_evt & ~$past(sound_evt)) |-> ##[1:6] !irq_n;
  endproperty
  a_raise: assert property (p_raise) else $error("enabled event lost");
  property p_port; sh_r[8] && $rose(proceed_evt) |-> ##[1:6] !irq_n; endproperty
  a_port: assert property (p_port) else $error("proceed event lost");
  property p_wo; s_rd(12'h000) |-> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("enable mask readable");
  property p_live; ser_shift_busy_n[*5] ##0 s_rd(12'h004) |-> prdata[3]; endproperty
  a_live: assert property (p_live) else $error("bit3 not live");
  property p_clr; (!proceed_evt)[*8] ##0 s_rd(12'h008) ##3 s_rd(12'h008) |-> !prdata[7];
  endproperty
  a_clr: assert property (p_clr) else $error("port flag kept");
  property p_rst; $rose(sys_reset_evt) |-> ##[1:6] !nmi_n; endproperty
  a_rst: assert property (p_rst) else $error("reset nmi lost");
  property p_vb; sh_r[10] && $rose(vblank_evt) |-> ##[1:6] !nmi_n; endproperty
  a_vb: assert property (p_vb) else $error("vblank nmi lost");
endmodule // igs_gate_sva
bind igs_gate igs_gate_sva u_sva (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .sound_evt(sound_evt), .ser_shift_busy_n(ser_shift_busy_n), .proceed_evt(proceed_evt),
  .vblank_evt(vblank_evt), .sys_reset_evt(sys_reset_evt), .irq_n(irq_n), .nmi_n(nmi_n));

// *** verification/igs_cpu_model.sv ***
// processor side: counts requests taken on both interrupt inputs
// assumes active-low registered request lines
module igs_cpu_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic irq_n,
  input wire logic nmi_n,
  output logic [7:0] irq_taken,
  output logic [7:0] nmi_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] old_r; // last levels of the two lines
  always_ff @(posedge ref_clk) begin
    old_r <= srst ? 2'h3 : {irq_n, nmi_n};
    irq_taken <= srst ? 8'h00 : irq_taken + {7'h00, old_r[1] & ~irq_n};
    nmi_taken <= srst ? 8'h00 : nmi_taken + {7'h00, old_r[0] & ~nmi_n};
  end
endmodule // igs_cpu_model

// *** verification/igs_gate_bench.sv ***
// self-checking bench of the interrupt gating block
// assumes 50 MHz ref_clk and a zero-wait apb slave
module igs_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q; // last read data
  logic pready;
  logic irq_n;
  logic nmi_n;
  logic busy_n = 1'h1; // shifter idle
  logic [12:0] ev = 13'h0000; // 7:0 sound, 8 proceed, 9 intr, 10 dlist, 11 vblank, 12 reset
  logic [7:0] irq_taken;
  logic [7:0] nmi_taken;
  int n_fail = 0;
  int samples_checked = 0;
  always #10 ref_clk = ~ref_clk;
  igs_gate DUT (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .sound_evt(ev[7:0]), .ser_shift_busy_n(busy_n), .proceed_evt(ev[8]),
    .interrupt_evt(ev[9]), .dlist_evt(ev[10]), .vblank_evt(ev[11]),
    .sys_reset_evt(ev[12]), .irq_n(irq_n), .nmi_n(nmi_n));
  igs_cpu_model cpu (.ref_clk(ref_clk), .srst(srst), .irq_n(irq_n), .nmi_n(nmi_n),
    .irq_taken(irq_taken), .nmi_taken(nmi_taken));
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    q = prdata;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  // event pin held three cycles so the synchroniser sees it
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'h1;
    repeat (3) @(posedge ref_clk);
    ev[i] <= 1'h0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_sources;
    for (int b = 0; b < 8; b++) begin
      if (b == 3) continue;
      pulse(b);
      `CHK("irq disabled", 1'h1, irq_n)
      apb(1'h1, 12'h000, 32'h1 << b);
      apb(1'h0, 12'h000, 32'h0);
      `CHK("mask read", 32'h0, q)
      pulse(b);
      `CHK("irq enabled", 1'h0, irq_n)
      apb(1'h0, 12'h004, 32'h0);
      `CHK("status", 8'h01 << b, q[7:0] & 8'hf7)
      apb(1'h1, 12'h000, 32'h0);
      apb(1'h0, 12'h004, 32'h0);
      `CHK("cleared", 8'h08, q[7:0])
      `CHK("irq off", 1'h1, irq_n)
    end
    @(posedge ref_clk);
    busy_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    apb(1'h0, 12'h004, 32'h0);
    `CHK("live bit3", 1'h0, q[3])
    @(posedge ref_clk);
    busy_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    apb(1'h0, 12'h004, 32'h0);
    `CHK("live bit3 back", 1'h1, q[3])
    $display("sources done");
  endtask
  task automatic t_port(input int p);
    logic [11:0] a;
    a = p ? 12'h00c : 12'h008;
    pulse(8 + p);
    `CHK("port off", 1'h1, irq_n)
    apb(1'h0, a, 32'h0);
    apb(1'h1, a, 32'h01);
    pulse(8 + p);
    `CHK("port irq", 1'h0, irq_n)
    apb(1'h0, a, 32'h0);
    `CHK("port flag", 32'h81, q)
    apb(1'h0, a, 32'h0);
    `CHK("flag cleared", 32'h01, q)
    `CHK("port released", 1'h1, irq_n)
    apb(1'h1, a, 32'h0);
    $display("port done");
  endtask
  task automatic t_nmi;
    apb(1'h1, 12'h010, 32'h02);
    pulse(10);
    `CHK("dlist masked", 1'h1, nmi_n)
    pulse(11);
    `CHK("vblank nmi", 2'h2, {irq_n, nmi_n})
    apb(1'h1, 12'h014, 32'h07);
    apb(1'h1, 12'h010, 32'h0);
    pulse(12);
    `CHK("reset nmi", 1'h0, nmi_n)
    apb(1'h1, 12'h014, 32'h07);
    apb(1'h0, 12'h03c, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("nmi counts", 16'h0902, {irq_taken, nmi_taken})
    $display("nmi done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'h0;
    t_sources;
    t_port(0);
    t_port(1);
    t_nmi;
    stop_test;
  end
  // watchdog: the run needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_fail++;
    stop_test;
  end
endmodule // igs_gate_bench
